//--- common/cmb_consts.svh
// constants for the conditional microbranch block: offsets, fields, resets, opcodes, counts
`ifndef CMB_CONSTS_SVH
`define CMB_CONSTS_SVH

`define CMB_OFF_CTRL_WORD 8'h00
`define CMB_OFF_FLAGS     8'h04
`define CMB_OFF_RESULT    8'h08
`define CMB_OFF_LOC       8'h0c
`define CMB_OFF_XLAT      8'h10
`define CMB_OFF_STATUS    8'h14

`define CMB_FLAG_ZB  0
`define CMB_FLAG_NB  1
`define CMB_FLAG_C8  2
`define CMB_FLAG_ICC 3

`define CMB_ST_BUSY   0
`define CMB_ST_TAKEN  1
`define CMB_ST_BRANCH 2
`define CMB_ST_CYC_LO 4

`define CMB_RST_LOC   11'h000
`define CMB_RST_XLAT  8'h00
`define CMB_RST_FLAGS 4'h0
`define CMB_RST_WORD  16'h0000

`define CMB_OP_BZ_CLR 8'h10
`define CMB_OP_BZ_SET 8'h11
`define CMB_OP_BC_CLR 8'h12
`define CMB_OP_BC_SET 8'h13
`define CMB_OP_BI_CLR 8'h14
`define CMB_OP_BI_SET 8'h15
`define CMB_OP_BN_CLR 8'h16
`define CMB_OP_BN_SET 8'h17

`define CMB_BRANCH_CYCLES 4'h2
`define CMB_PLAIN_CYCLES  4'h1

`define CMB_RESP_OKAY   2'b00
`define CMB_RESP_SLVERR 2'b10

`endif

//--- common/cmb_pkg.sv
// types shared by the conditional microbranch block
`default_nettype none
package cmb_pkg;
	typedef logic [15:0] cmb_word_t;
	typedef logic [10:0] cmb_loc_t;
	typedef logic [3:0]  cmb_flags_t;

	typedef enum logic [3:0] {
		cmb_kind_none,
		cmb_kind_bz_clr,
		cmb_kind_bz_set,
		cmb_kind_bn_clr,
		cmb_kind_bn_set,
		cmb_kind_bi_clr,
		cmb_kind_bi_set,
		cmb_kind_bc_clr,
		cmb_kind_bc_set
	} cmb_kind_t;

	typedef enum logic [1:0] {
		cmb_st_idle,
		cmb_st_cyc1,
		cmb_st_cyc2
	} cmb_state_t;
endpackage : cmb_pkg
`default_nettype wire

//--- common/cmb_dec_if.sv
// decoder link between the sequencer and the branch decoder
`timescale 1ns/100ps
`default_nettype none
interface cmb_dec_if;
	import cmb_pkg::*;
	cmb_word_t  word;
	cmb_flags_t flags;
	cmb_kind_t  kind;
	logic       is_branch;
	logic       taken;
	logic [7:0] target;

	modport dec (input word, input flags, output kind, output is_branch, output taken, output target);
	modport seq (output word, output flags, input kind, input is_branch, input taken, input target);
endinterface : cmb_dec_if
`default_nettype wire

//--- hw/cmb_decoder.sv
// branch opcode decoder and flag test for the conditional microbranch block
`timescale 1ns/100ps
`default_nettype none
`include "cmb_consts.svh"
module cmb_decoder (
	cmb_dec_if.dec dif
);
	import cmb_pkg::*;

	// opcode is taken from bits above the target field only
	always_comb begin
		if (dif.word[15:8] == `CMB_OP_BZ_CLR) begin
			dif.kind = cmb_kind_bz_clr;
		end else if (dif.word[15:8] == `CMB_OP_BZ_SET) begin
			dif.kind = cmb_kind_bz_set;
		end else if (dif.word[15:8] == `CMB_OP_BN_CLR) begin
			dif.kind = cmb_kind_bn_clr;
		end else if (dif.word[15:8] == `CMB_OP_BN_SET) begin
			dif.kind = cmb_kind_bn_set;
		end else if (dif.word[15:8] == `CMB_OP_BI_CLR) begin
			dif.kind = cmb_kind_bi_clr;
		end else if (dif.word[15:8] == `CMB_OP_BI_SET) begin
			dif.kind = cmb_kind_bi_set;
		end else if (dif.word[15:8] == `CMB_OP_BC_CLR) begin
			dif.kind = cmb_kind_bc_clr;
		end else if (dif.word[15:8] == `CMB_OP_BC_SET) begin
			dif.kind = cmb_kind_bc_set;
		end else begin
			dif.kind = cmb_kind_none;
		end
	end

	// flag test: each pair tests one flag for clear or set
	always_comb begin
		case (dif.kind)
			cmb_kind_bz_clr: dif.taken = ~dif.flags[`CMB_FLAG_ZB];
			cmb_kind_bz_set: dif.taken = dif.flags[`CMB_FLAG_ZB];
			cmb_kind_bn_clr: dif.taken = ~dif.flags[`CMB_FLAG_NB];
			cmb_kind_bn_set: dif.taken = dif.flags[`CMB_FLAG_NB];
			cmb_kind_bi_clr: dif.taken = ~dif.flags[`CMB_FLAG_ICC];
			cmb_kind_bi_set: dif.taken = dif.flags[`CMB_FLAG_ICC];
			cmb_kind_bc_clr: dif.taken = ~dif.flags[`CMB_FLAG_C8];
			cmb_kind_bc_set: dif.taken = dif.flags[`CMB_FLAG_C8];
			default:         dif.taken = 1'b0;
		endcase
	end

	// low byte is purely the in-page target
	assign dif.is_branch = (dif.kind != cmb_kind_none);
	assign dif.target    = dif.word[7:0];
endmodule : cmb_decoder
`default_nettype wire

//--- hw/cmb_microbranch.sv
// conditional in-page microbranch sequencer with an axi4-lite register slave
//
// Implementation choices: the AXI4-Lite slave port and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none
`include "cmb_consts.svh"

// Notes on behaviour
// - byte-zero-clear branch loads its target only when byte zero flag is 0.
// - high byte 0x11 is byte-zero-set; taken when byte zero flag is 1.
// - high byte 0x16 is byte-negative-clear; taken when byte negative flag is 0.
// - high byte 0x17 is byte-negative-set; taken when byte negative flag is 1.
// - high byte 0x14 is indirect-clear; taken when indirect condition flag is 0.
// - high byte 0x15 is indirect-set; taken when indirect condition flag is 1.
// - high byte 0x12 is carry-out-clear; taken when carry out flag is 0.
// - taken branch copies control word bits 7:0 into location counter bits 7:0.
// - every conditional branch lasts exactly two microcycles, taken or not.
// - translation output low byte is ignored while a branch executes.
// - a branch changes only the location counter and the status taken/branch/cycle fields, no flags or other registers.
// - location counter bits 10:8 stay unchanged in the second microcycle; target stays in current page.
// - page is fixed in the first microcycle when the sequential address loads.
// - untaken branch leaves the sequential address in the location counter.
// - high byte 0x10 decodes as byte-zero-clear.
// - high byte 0x13 is carry-out-set; taken when carry out flag is 1.
// - byte zero flag is set when last result is zero, else cleared.
module cmb_microbranch (
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	output cmb_pkg::cmb_loc_t location_counter,
	output logic             busy
);
	import cmb_pkg::*;

	////////////////////////////////////////////////////////////////////////////////
	// state

	cmb_state_t  state_r;
	cmb_word_t   word_r;
	cmb_flags_t  flags_r;
	cmb_loc_t    loc_r;
	logic [7:0]  xlat_r;
	logic        taken_r;
	logic        branch_r;
	logic [3:0]  cycles_r;
	logic [7:0]  aw_addr_r;
	logic        aw_full_r;
	logic [31:0] w_data_r;
	logic [3:0]  w_strb_r;
	logic        w_full_r;
	logic        bvalid_r;
	logic [1:0]  bresp_r;
	logic        rvalid_r;
	logic [1:0]  rresp_r;
	logic [31:0] rdata_r;
	logic        do_write;
	logic        wr_ok;
	logic        wr_word;
	logic        wr_flags;
	logic        wr_result;
	logic        wr_loc;
	logic        wr_xlat;
	logic [31:0] wr_val;
	logic [31:0] rd_val;
	logic        rd_ok;
	cmb_loc_t    seq_addr;

	cmb_dec_if dif ();

	// decoder sees the latched control word and the live flags
	assign dif.word  = word_r;
	assign dif.flags = flags_r;

	cmb_decoder u_dec (
		.dif (dif)
	);

	////////////////////////////////////////////////////////////////////////////////
	// axi4-lite write channels

	// merge strobed bytes over the old value; unstrobed lanes keep their contents
	function automatic logic [31:0] merge_strb(input logic [31:0] old_v, input logic [31:0] new_v,
		input logic [3:0] strb);
		logic [31:0] res;
		res = old_v;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				res[8*i +: 8] = new_v[8*i +: 8];
			end
		end
		return res;
	endfunction : merge_strb

	// address and data are held independently, so either may arrive first
	assign s_axi_awready = ~aw_full_r & ~bvalid_r;
	assign s_axi_wready  = ~w_full_r & ~bvalid_r;
	assign s_axi_bvalid  = bvalid_r;
	assign s_axi_bresp   = bresp_r;
	assign do_write      = aw_full_r & w_full_r & ~bvalid_r;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_full_r <= 1'b0;
			aw_addr_r <= 8'h00;
		end else if (s_axi_awvalid && s_axi_awready) begin
			aw_full_r <= 1'b1;
			aw_addr_r <= s_axi_awaddr;
		end else if (do_write) begin
			aw_full_r <= 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			w_full_r <= 1'b0;
			w_data_r <= 32'h00000000;
			w_strb_r <= 4'h0;
		end else if (s_axi_wvalid && s_axi_wready) begin
			w_full_r <= 1'b1;
			w_data_r <= s_axi_wdata;
			w_strb_r <= s_axi_wstrb;
		end else if (do_write) begin
			w_full_r <= 1'b0;
		end
	end

	// write decode; control word and counter writes are refused while an instruction runs
	always_comb begin
		wr_word   = 1'b0;
		wr_flags  = 1'b0;
		wr_result = 1'b0;
		wr_loc    = 1'b0;
		wr_xlat   = 1'b0;
		wr_ok     = 1'b1;
		if (aw_addr_r == `CMB_OFF_CTRL_WORD) begin
			wr_word = (state_r == cmb_st_idle);
			wr_ok   = (state_r == cmb_st_idle);
		end else if (aw_addr_r == `CMB_OFF_FLAGS) begin
			wr_flags = 1'b1;
		end else if (aw_addr_r == `CMB_OFF_RESULT) begin
			wr_result = 1'b1;
		end else if (aw_addr_r == `CMB_OFF_LOC) begin
			wr_loc = (state_r == cmb_st_idle);
			wr_ok  = (state_r == cmb_st_idle);
		end else if (aw_addr_r == `CMB_OFF_XLAT) begin
			wr_xlat = 1'b1;
		end else if (aw_addr_r == `CMB_OFF_STATUS) begin
			wr_ok = 1'b1;                                     // read-only, write dropped
		end else begin
			wr_ok = 1'b0;
		end
	end

	assign wr_val = merge_strb(32'h00000000, w_data_r, w_strb_r);

	// response stands until the master takes it
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bvalid_r <= 1'b0;
			bresp_r  <= `CMB_RESP_OKAY;
		end else if (do_write) begin
			bvalid_r <= 1'b1;
			bresp_r  <= wr_ok ? `CMB_RESP_OKAY : `CMB_RESP_SLVERR;
		end else if (s_axi_bready) begin
			bvalid_r <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// axi4-lite read channels

	assign s_axi_arready = ~rvalid_r;
	assign s_axi_rvalid  = rvalid_r;
	assign s_axi_rresp   = rresp_r;
	assign s_axi_rdata   = rdata_r;

	always_comb begin
		rd_ok  = 1'b1;
		rd_val = 32'h00000000;
		if (s_axi_araddr == `CMB_OFF_CTRL_WORD) begin
			rd_val[15:0] = word_r;
		end else if (s_axi_araddr == `CMB_OFF_FLAGS) begin
			rd_val[3:0] = flags_r;
		end else if (s_axi_araddr == `CMB_OFF_RESULT) begin
			rd_val = 32'h00000000;                            // write-only
		end else if (s_axi_araddr == `CMB_OFF_LOC) begin
			rd_val[10:0] = loc_r;
		end else if (s_axi_araddr == `CMB_OFF_XLAT) begin
			rd_val[7:0] = xlat_r;
		end else if (s_axi_araddr == `CMB_OFF_STATUS) begin
			rd_val[`CMB_ST_BUSY]   = (state_r != cmb_st_idle);
			rd_val[`CMB_ST_TAKEN]  = taken_r;
			rd_val[`CMB_ST_BRANCH] = branch_r;
			rd_val[`CMB_ST_CYC_LO +: 4] = cycles_r;
		end else begin
			rd_ok = 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rvalid_r <= 1'b0;
			rresp_r  <= `CMB_RESP_OKAY;
			rdata_r  <= 32'h00000000;
		end else if (s_axi_arvalid && s_axi_arready) begin
			rvalid_r <= 1'b1;
			rresp_r  <= rd_ok ? `CMB_RESP_OKAY : `CMB_RESP_SLVERR;
			rdata_r  <= rd_val;
		end else if (s_axi_rready) begin
			rvalid_r <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// software-owned registers

	// control word is latched once per instruction; a write launches execution
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			word_r <= `CMB_RST_WORD;
		end else if (do_write && wr_word) begin
			word_r <= 16'(merge_strb({16'h0000, word_r}, w_data_r, w_strb_r));
		end
	end

	// flags change only by software; the sequencer never writes them
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			flags_r <= `CMB_RST_FLAGS;
		end else if (do_write && wr_result) begin
			flags_r[`CMB_FLAG_ZB] <= (wr_val[15:0] == 16'h0000);
			flags_r[`CMB_FLAG_NB] <= wr_val[7];
		end else if (do_write && wr_flags) begin
			flags_r <= 4'(merge_strb({28'h0000000, flags_r}, w_data_r, w_strb_r));
		end
	end

	// translation output stand-in; only plain instructions merge it
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			xlat_r <= `CMB_RST_XLAT;
		end else if (do_write && wr_xlat) begin
			xlat_r <= wr_val[7:0];
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// sequencer

	// sequential address wraps inside the 11-bit space like the counter itself
	assign seq_addr = loc_r + 11'h001;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state_r <= cmb_st_idle;
		end else begin
			case (state_r)
				cmb_st_idle: begin
					if (do_write && wr_word) begin
						state_r <= cmb_st_cyc1;
					end
				end
				cmb_st_cyc1: begin
					state_r <= dif.is_branch ? cmb_st_cyc2 : cmb_st_idle;
				end
				cmb_st_cyc2: begin
					state_r <= cmb_st_idle;
				end
				default: begin
					state_r <= cmb_st_idle;
				end
			endcase
		end
	end

	// location counter: the only state a branch touches apart from the sequencer state and the status fields
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			loc_r <= `CMB_RST_LOC;
		end else begin
			case (state_r)
				cmb_st_idle: begin
					if (do_write && wr_loc) begin
						loc_r <= wr_val[10:0];
					end
				end
				cmb_st_cyc1: begin
					if (dif.is_branch) begin
						loc_r <= seq_addr;
					end else begin
						loc_r <= {seq_addr[10:8], seq_addr[7:0] | xlat_r};
					end
				end
				cmb_st_cyc2: begin
					if (taken_r) begin
						loc_r <= {loc_r[10:8], word_r[7:0]};
					end
				end
				default: begin
					loc_r <= loc_r;
				end
			endcase
		end
	end

	// condition is caught at the first microcycle, after any earlier flag update
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			taken_r  <= 1'b0;
			branch_r <= 1'b0;
		end else if (state_r == cmb_st_cyc1) begin
			taken_r  <= dif.taken;
			branch_r <= dif.is_branch;
		end
	end

	// microcycles used by the last instruction, for software to check
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cycles_r <= 4'h0;
		end else if (state_r == cmb_st_cyc1) begin
			cycles_r <= dif.is_branch ? `CMB_BRANCH_CYCLES : `CMB_PLAIN_CYCLES;
		end
	end

	assign location_counter = loc_r;
	assign busy             = (state_r != cmb_st_idle);
endmodule : cmb_microbranch
`default_nettype wire

//--- tb/cmb_microbranch_assertions.sv
// assertion checker for the conditional microbranch block
`timescale 1ns/100ps
`default_nettype none
module cmb_microbranch_assertions (
	input wire logic              aclk,
	input wire logic              aresetn,
	input wire logic [7:0]        s_axi_awaddr,
	input wire logic              s_axi_awvalid,
	input wire logic              s_axi_awready,
	input wire logic [31:0]       s_axi_wdata,
	input wire logic              s_axi_wvalid,
	input wire logic              s_axi_wready,
	input wire logic [1:0]        s_axi_bresp,
	input wire logic              s_axi_bvalid,
	input wire logic              s_axi_bready,
	input wire logic              s_axi_arvalid,
	input wire logic              s_axi_arready,
	input wire logic [31:0]       s_axi_rdata,
	input wire logic              s_axi_rvalid,
	input wire logic              s_axi_rready,
	input wire cmb_pkg::cmb_loc_t location_counter,
	input wire logic              busy
);
	import cmb_pkg::*;
	cmb_word_t  word_r;
	cmb_flags_t flg_r;
	cmb_loc_t   lc0_r;
	cmb_loc_t   seq;
	logic       br;
	logic       tk;
	logic       wr_go;
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	////////////////////////////////////////////////////////////////////////////////
	// shadows assume address and data arrive together, as the bench always offers them
	assign wr_go = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	assign br    = word_r[15:11] == 5'b00010;
	assign seq   = lc0_r + 11'h001;
	assign tk    = (word_r[10:9] == 2'b00 ? flg_r[0] : word_r[10:9] == 2'b01 ? flg_r[2] :
	                word_r[10:9] == 2'b10 ? flg_r[3] : flg_r[1]) == word_r[8];
	// last launched word, refused while busy
	always_ff @(posedge aclk) begin
		if (!aresetn)
			word_r <= '0;
		else if (wr_go && s_axi_awaddr == 8'h00 && !busy)
			word_r <= s_axi_wdata[15:0];
	end
	// flag shadow; the bench never writes flags mid-instruction
	always_ff @(posedge aclk) begin
		if (!aresetn)
			flg_r <= '0;
		else if (wr_go && s_axi_awaddr == 8'h04)
			flg_r <= s_axi_wdata[3:0];
		else if (wr_go && s_axi_awaddr == 8'h08)
			flg_r[1:0] <= {s_axi_wdata[7], s_axi_wdata[15:0] == 16'h0000};
	end
	// location counter as it stood before the instruction started
	always_ff @(posedge aclk) begin
		if (!aresetn)
			lc0_r <= '0;
		else if (!busy)
			lc0_r <= location_counter;
	end
	////////////////////////////////////////////////////////////////////////////////
	AST_BR_TWO_CYC: assert property ($rose(busy) && br |=> busy ##1 !busy)
		else $error("branch did not take two microcycles");
	AST_SEQ_LOAD: assert property ($rose(busy) && br |=> location_counter == seq)
		else $error("sequential address not loaded in first microcycle");
	AST_PAGE_KEPT: assert property ($rose(busy) && br |=> ##1
		location_counter[10:8] == $past(location_counter[10:8]))
		else $error("page bits changed in second microcycle");
	AST_BR_DEST: assert property ($rose(busy) && br |=> ##1
		location_counter[7:0] == (tk ? word_r[7:0] : seq[7:0]))
		else $error("wrong branch destination");
	AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped before accepted");
	AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped before accepted");
	AST_R_ANSWER: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read answer late");
	AST_AW_BLOCK: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("new write accepted while response pending");
	cover property ($rose(busy) && br && tk);
	cover property ($rose(busy) && br && !tk);
	cover property ($rose(busy) && !br);
endmodule : cmb_microbranch_assertions
`default_nettype wire

//--- tb/conditional_microbranch_test.sv
// self-checking bench for the conditional microbranch block
`timescale 1ns/100ps
`default_nettype none
`include "cmb_consts.svh"
module conditional_microbranch_test;
	import cmb_pkg::*;
	logic        aclk = 1'b0;
	logic        aresetn = 1'b0;
	logic [7:0]  s_axi_awaddr = '0;
	logic        s_axi_awvalid = 1'b0;
	logic [31:0] s_axi_wdata = '0;
	logic [3:0]  s_axi_wstrb = 4'hf;
	logic        s_axi_wvalid = 1'b0;
	logic        s_axi_bready = 1'b0;
	logic [7:0]  s_axi_araddr = '0;
	logic        s_axi_arvalid = 1'b0;
	logic        s_axi_rready = 1'b0;
	logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, busy;
	logic [1:0]  s_axi_bresp, s_axi_rresp;
	logic [31:0] s_axi_rdata;
	cmb_loc_t    location_counter;
	logic [31:0] seed = 32'h10;
	logic [31:0] v;
	int          n_mismatch = 0;
	int          n_compared = 0;
	int          cyc = 0;
	cmb_loc_t    m_lc = '0;
	cmb_flags_t  m_fl = '0;
	logic [7:0]  m_xl = '0;
	int          bit_of [4] = '{0, 2, 3, 1};
	cmb_microbranch uut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
		.s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
		.s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
		.s_axi_rready, .location_counter, .busy);
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		forever #5 aclk = ~aclk;
	end
	// a hang counts as a mismatch
	always @(posedge aclk) begin
		cyc++;
		if (cyc == 20000) begin
			n_mismatch++;
			give_verdict();
		end
	end
	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction : rnd
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("[ERR] %0t got %h expected %h", $time, seen, exp);
		end
	endtask : chk
	task automatic give_verdict();
		if (n_mismatch == 0 && n_compared > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : give_verdict
	// ready goes up with the request or, at random, only once the answer stands, so the slave must hold it
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
		logic        aw;
		logic        w;
		logic [31:0] r;
		r = rnd();
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_awvalid <= 1'b1;
		s_axi_wdata <= d;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= r[0];
		aw = 1'b1;
		w = 1'b1;
		while (aw || w) begin
			@(posedge aclk);
			if (aw && s_axi_awready === 1'b1) begin
				aw = 1'b0;
				s_axi_awvalid <= 1'b0;
			end
			if (w && s_axi_wready === 1'b1) begin
				w = 1'b0;
				s_axi_wvalid <= 1'b0;
			end
		end
		do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
		if (r[0] == 1'b0) begin
			s_axi_bready <= 1'b1;
			do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
		end
		chk({30'h0, s_axi_bresp}, {30'h0, e});
		s_axi_bready <= 1'b0;
	endtask : axi_wr
	task automatic axi_rd(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] e);
		logic [31:0] r;
		r = rnd();
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= r[0];
		do @(posedge aclk); while (s_axi_arready !== 1'b1);
		s_axi_arvalid <= 1'b0;
		do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
		if (r[0] == 1'b0) begin
			s_axi_rready <= 1'b1;
			do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
		end
		chk(s_axi_rdata, exp);
		chk({30'h0, s_axi_rresp}, {30'h0, e});
		s_axi_rready <= 1'b0;
	endtask : axi_rd
	// launch one word and compare every visible effect with the model
	task automatic run_word(input cmb_word_t w);
		logic     br;
		logic     tk;
		cmb_loc_t seq;
		br = w[15:11] == 5'b00010;
		tk = br && (m_fl[bit_of[w[10:9]]] == w[8]);
		seq = m_lc + 11'h001;
		m_lc = br ? (tk ? {seq[10:8], w[7:0]} : seq) : {seq[10:8], seq[7:0] | m_xl};
		axi_wr(`CMB_OFF_CTRL_WORD, {16'h0, w}, `CMB_RESP_OKAY);
		while (busy === 1'b1) @(posedge aclk);
		axi_rd(`CMB_OFF_LOC, {21'h0, m_lc}, `CMB_RESP_OKAY);
		axi_rd(`CMB_OFF_STATUS, {24'h0, br ? `CMB_BRANCH_CYCLES : `CMB_PLAIN_CYCLES, 1'b0, br, tk, 1'b0},
			`CMB_RESP_OKAY);
		axi_rd(`CMB_OFF_FLAGS, {28'h0, m_fl}, `CMB_RESP_OKAY);
		axi_rd(`CMB_OFF_XLAT, {24'h0, m_xl}, `CMB_RESP_OKAY);
	endtask : run_word
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (5) @(posedge aclk);
		aresetn <= 1'b1;
		axi_rd(`CMB_OFF_LOC, 32'h0, `CMB_RESP_OKAY);
		axi_rd(`CMB_OFF_STATUS, 32'h0, `CMB_RESP_OKAY);
		axi_rd(8'h18, 32'h0, `CMB_RESP_SLVERR);
		axi_wr(8'h1c, rnd(), `CMB_RESP_SLVERR);
		// every branch kind, taken and not; first two cross a page edge and wrap
		for (int k = 0; k < 8; k++) begin
			for (int t = 0; t < 2; t++) begin
				v = rnd();
				m_lc = (k == 0) ? 11'h0ff : (k == 1) ? 11'h7ff : v[10:0];
				m_fl = v[14:11];
				m_fl[bit_of[k[2:1]]] = (t == 1) ? k[0] : !k[0];
				m_xl = v[23:16] | 8'h01;
				axi_wr(`CMB_OFF_LOC, {21'h0, m_lc}, `CMB_RESP_OKAY);
				axi_wr(`CMB_OFF_FLAGS, {28'h0, m_fl}, `CMB_RESP_OKAY);
				axi_wr(`CMB_OFF_XLAT, {24'h0, m_xl}, `CMB_RESP_OKAY);
				run_word({8'h10 + k[7:0], v[31:24]});
			end
		end
		// words around the branch range, including its neighbours
		for (int i = 0; i < 10; i++) begin
			v = rnd();
			run_word({8'h0c + {4'h0, v[11:8]}, v[7:0]});
		end
		// flags produced by a result, seen by the next branch
		axi_wr(`CMB_OFF_RESULT, 32'h0, `CMB_RESP_OKAY);
		m_fl[1:0] = 2'b01;
		run_word(16'h11a5);
		axi_wr(`CMB_OFF_RESULT, 32'h0180, `CMB_RESP_OKAY);
		m_fl[1:0] = 2'b10;
		run_word(16'h105a);
		give_verdict();
	end
endmodule : conditional_microbranch_test
bind cmb_microbranch cmb_microbranch_assertions chk (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
	.s_axi_awready, .s_axi_wdata, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
	.s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .location_counter, .busy);
`default_nettype wire
